// ==== design/swsc_device.sv ====
// device end of the chained switch monitor: sleep and wake sequencing
// assumes the link clock stops outside frames, the host keeps the
// chip-select lead and idle times of swsc_pkg, resetn is the supply monitor
`timescale 1ns/1ps
module swsc_device (
    // system clock and supply-monitor reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // serial chain segment and shared wake line
    swsc_link_if.device                    link,
    // switch contacts, not synchronous to clk
    input  wire logic [swsc_pkg::SW_N-1:0] sw,
    // mode and wake cause
    output logic                           asleep,
    output logic                           wake_flag
);

    // ==============================================================
    // declarations
    logic [swsc_pkg::DEV_BITS-1:0] sr;
    logic                          first;
    logic [swsc_pkg::DEV_BITS-2:0] status_snap;

    logic                          cs_m;
    logic                          cs_s;
    logic                          cs_d;
    logic [swsc_pkg::SW_N-1:0]     sw_m;
    logic [swsc_pkg::SW_N-1:0]     sw_s;
    logic [swsc_pkg::SW_N-1:0]     sw_d;
    logic                          wk_m;
    logic                          wk_s;
    logic [2:0]                    sw_age;

    swsc_pkg::swsc_mode_t          mode;
    swsc_pkg::swsc_mode_t          next_mode;
    logic [swsc_pkg::SW_N-1:0]     wake_en;
    logic                          chg_seen;
    logic                          flag_late;
    logic                          armed;

    logic                          cs_rise;
    logic                          cs_fall;
    logic                          sw_chg_any;
    logic                          sw_wake;
    logic                          line_wake;
    logic [1:0]                    frame_op;

    function automatic logic [1:0] op_of(input logic [swsc_pkg::DEV_BITS-1:0] w);
        return w[swsc_pkg::OP_MSB:swsc_pkg::OP_LSB];
    endfunction : op_of

    // ==============================================================
    // link clock domain: shift stage
    // set asynchronously while chip select is high, so the first
    // rising edge of every frame is known without a free-running clock
    always_ff @(posedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end

    // status_snap is frozen while chip select is low, stable at every edge
    always_ff @(posedge link.sclk or negedge resetn) begin
        if (!resetn) begin
            sr <= '0;
        end else if (first) begin
            sr <= {status_snap, link.si};
        end else begin
            sr <= {sr[swsc_pkg::DEV_BITS-2:0], link.si};
        end
    end

    // serial out changes on falling edges; passes data on after 24 clocks,
    // so two devices in a chain need the full 48-clock frame
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            link.so <= 1'b0;
        end else begin
            link.so <= sr[swsc_pkg::DEV_BITS-1];
        end
    end

    // ==============================================================
    // synchronisers into clk
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cs_m <= 1'b1;
            cs_s <= 1'b1;
            cs_d <= 1'b1;
        end else begin
            cs_m <= link.cs_n;
            cs_s <= cs_m;
            cs_d <= cs_s;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sw_m   <= '0;
            sw_s   <= '0;
            sw_d   <= '0;
            sw_age <= '0;
        end else begin
            sw_m   <= sw;
            sw_s   <= sw_m;
            sw_d   <= sw_s;
            sw_age <= {sw_age[1:0], 1'b1};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wk_m <= 1'b0;
            wk_s <= 1'b0;
        end else begin
            wk_m <= link.wake_in;
            wk_s <= wk_m;
        end
    end

    // ==============================================================
    // events
    // sr is read only at the chip-select rise, when the link clock is still
    assign cs_rise    = cs_s & ~cs_d;
    assign cs_fall    = ~cs_s & cs_d;
    // sw_age hides the jump from the reset value to the real pin level
    assign sw_chg_any = |(sw_s ^ sw_d) & sw_age[2];
    assign sw_wake    = |((sw_s ^ sw_d) & wake_en) & sw_age[2];
    assign line_wake  = armed & ~wk_s;
    assign frame_op   = op_of(sr);

    // ==============================================================
    // mode sequencing
    always_comb begin
        next_mode = mode;
        case (mode)
            swsc_pkg::MODE_NORMAL: begin
                if (cs_rise && frame_op == swsc_pkg::OP_SLEEP && !chg_seen && !sw_chg_any) begin
                    next_mode = swsc_pkg::MODE_SLEEP;
                end
            end
            swsc_pkg::MODE_SLEEP: begin
                if (cs_fall) begin
                    next_mode = swsc_pkg::MODE_NORMAL;
                end else if (sw_wake) begin
                    next_mode = swsc_pkg::MODE_NORMAL;
                end else if (line_wake) begin
                    next_mode = swsc_pkg::MODE_NORMAL;
                end
            end
            default: begin
                next_mode = swsc_pkg::MODE_NORMAL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode   <= swsc_pkg::MODE_NORMAL;
            asleep <= 1'b0;
        end else begin
            mode   <= next_mode;
            asleep <= (next_mode == swsc_pkg::MODE_SLEEP);
        end
    end

    // open drain: only ever pulls low; released line floats high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            link.wake_oe  <= 1'b1;
            link.wake_out <= 1'b0;
        end else begin
            link.wake_oe  <= (next_mode == swsc_pkg::MODE_NORMAL);
            link.wake_out <= 1'b0;
        end
    end

    // our own release takes a few cycles to reach wk_s; without arming,
    // the stale low level would wake us straight back up
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else if (mode == swsc_pkg::MODE_SLEEP) begin
            armed <= armed | wk_s;
        end else begin
            armed <= 1'b0;
        end
    end

    // ==============================================================
    // change during a frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            chg_seen <= 1'b0;
        end else if (!cs_s && sw_chg_any) begin
            chg_seen <= 1'b1;
        end else if (cs_fall) begin
            chg_seen <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_late <= 1'b0;
        end else if (!cs_s && sw_wake) begin
            flag_late <= 1'b1;
        end else if (cs_fall) begin
            flag_late <= 1'b0;
        end
    end

    // ==============================================================
    // configuration and wake cause
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_en <= swsc_pkg::WAKE_EN_RST;
        end else if (cs_rise && mode == swsc_pkg::MODE_NORMAL && frame_op == swsc_pkg::OP_CONFIG) begin
            wake_en <= sr[swsc_pkg::SW_N-1:0];
        end
    end

    // set wins over the clear; a set after the frame began is not cleared
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_flag <= 1'b0;
        end else if (sw_wake) begin
            wake_flag <= 1'b1;
        end else if (cs_rise && frame_op == swsc_pkg::OP_STATUS && !flag_late) begin
            wake_flag <= 1'b0;
        end
    end

    // updated only while the select is idle, so the shift stage sees it still
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_snap <= '0;
        end else if (cs_s) begin
            status_snap <= {wake_flag, sw_s};
        end
    end

endmodule : swsc_device

// ==== design/swsc_host.sv ====
// host end of the chained switch monitor link
// assumes two devices chained on one select, clk at 10 MHz,
// and a bench that joins the interface segments of the chain
`timescale 1ns/1ps
module swsc_host #(
    parameter int SETTLE_CYC  = swsc_pkg::SETTLE_CYC,
    parameter int REFRESH_CYC = swsc_pkg::REFRESH_CYC
) (
    // system
    input  wire logic                            clk,
    input  wire logic                            resetn,
    // chain link
    swsc_link_if.host                            link,
    // request
    input  wire logic                            op_valid,
    input  wire swsc_pkg::swsc_op_t              op_code,
    input  wire logic [swsc_pkg::SW_N-1:0]       cfg_data,
    output logic                                 op_ready,
    // answer
    output logic                                 rx_valid,
    output logic [swsc_pkg::FRAME_BITS-1:0]      rx_word,
    output logic                                 refused
);

    // ==============================================================
    // declarations
    typedef enum {H_IDLE, H_LEAD, H_SHIFT, H_TAIL, H_GAP, H_SETTLE} swsc_hstate_t;

    swsc_hstate_t                     state;
    swsc_pkg::swsc_op_t               cur;
    logic [31:0]                      cnt;
    logic [swsc_pkg::BIT_W-1:0]       bits;
    logic [swsc_pkg::FRAME_BITS-1:0]  tx;
    logic [swsc_pkg::FRAME_BITS-1:0]  rx;
    logic                             pass2;
    logic                             status_ok;
    logic [swsc_pkg::SW_N-1:0]        cfg_shadow;
    logic                             cfg_valid;
    logic [31:0]                      ref_cnt;
    logic                             refresh_due;
    logic                             miso_m;
    logic                             miso_s;
    logic                             take_op;
    logic                             refresh_take;

    // same word to every device of the chain
    function automatic logic [swsc_pkg::FRAME_BITS-1:0] frame_of(input logic [1:0] op,
                                                               input logic [swsc_pkg::SW_N-1:0] d);
        return {swsc_pkg::N_DEV{op, d}};
    endfunction : frame_of

    function automatic logic [1:0] opcode_of(input swsc_pkg::swsc_op_t r);
        case (r)
            swsc_pkg::REQ_SLEEP:  return swsc_pkg::OP_SLEEP;
            swsc_pkg::REQ_CONFIG: return swsc_pkg::OP_CONFIG;
            default:              return swsc_pkg::OP_STATUS;
        endcase
    endfunction : opcode_of

    assign take_op      = (state == H_IDLE) && op_valid && op_ready;
    assign refresh_take = (state == H_IDLE) && !take_op && refresh_due && cfg_valid;

    // ==============================================================
    // serial input synchroniser
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            miso_m <= 1'b0;
            miso_s <= 1'b0;
        end else begin
            miso_m <= link.so;
            miso_s <= miso_m;
        end
    end

    // ==============================================================
    // periodic configuration rewrite, since a device may reset alone
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ref_cnt     <= '0;
            refresh_due <= 1'b0;
        end else if (ref_cnt == 32'(REFRESH_CYC - 1)) begin
            ref_cnt     <= '0;
            refresh_due <= 1'b1;
        end else begin
            ref_cnt <= ref_cnt + 32'h1;
            if (refresh_take) begin
                refresh_due <= 1'b0;
            end
        end
    end

    // ==============================================================
    // frame sequencer
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state      <= H_IDLE;
            cur        <= swsc_pkg::REQ_STATUS;
            cnt        <= '0;
            bits       <= '0;
            tx         <= '0;
            rx         <= '0;
            pass2      <= 1'b0;
            status_ok  <= 1'b0;
            cfg_shadow <= swsc_pkg::WAKE_EN_RST;
            cfg_valid  <= 1'b0;
            op_ready   <= 1'b1;
            rx_valid   <= 1'b0;
            rx_word    <= '0;
            refused    <= 1'b0;
            link.sclk  <= 1'b0;
            link.cs_n  <= 1'b1;
            link.si    <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            refused  <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (take_op && op_code == swsc_pkg::REQ_SLEEP && !status_ok) begin
                        refused <= 1'b1;
                    end else if (take_op) begin
                        cur       <= op_code;
                        tx        <= frame_of(opcode_of(op_code), cfg_data);
                        link.cs_n <= 1'b0;
                        cnt       <= 32'(swsc_pkg::CS_LEAD_CYC - 1);
                        op_ready  <= 1'b0;
                        state     <= H_LEAD;
                        if (op_code == swsc_pkg::REQ_CONFIG) begin
                            cfg_shadow <= cfg_data;
                            cfg_valid  <= 1'b1;
                        end
                    end else if (refresh_take) begin
                        cur       <= swsc_pkg::REQ_CONFIG;
                        tx        <= frame_of(swsc_pkg::OP_CONFIG, cfg_shadow);
                        link.cs_n <= 1'b0;
                        cnt       <= 32'(swsc_pkg::CS_LEAD_CYC - 1);
                        op_ready  <= 1'b0;
                        state     <= H_LEAD;
                    end
                end
                H_LEAD: begin
                    if (cnt != 32'h0) begin
                        cnt <= cnt - 32'h1;
                    end else begin
                        link.si <= tx[swsc_pkg::FRAME_BITS-1];
                        bits    <= '0;
                        cnt     <= 32'(swsc_pkg::SCLK_HALF_CYC - 1);
                        state   <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (cnt != 32'h0) begin
                        cnt <= cnt - 32'h1;
                    end else if (!link.sclk) begin
                        link.sclk <= 1'b1;
                        rx        <= {rx[swsc_pkg::FRAME_BITS-2:0], miso_s};
                        cnt       <= 32'(swsc_pkg::SCLK_HALF_CYC - 1);
                    end else begin
                        link.sclk <= 1'b0;
                        tx        <= {tx[swsc_pkg::FRAME_BITS-2:0], 1'b0};
                        link.si   <= tx[swsc_pkg::FRAME_BITS-2];
                        bits      <= bits + 6'h1;
                        cnt       <= 32'(swsc_pkg::SCLK_HALF_CYC - 1);
                        if (bits == 6'(swsc_pkg::FRAME_BITS - 1)) begin
                            cnt   <= 32'(swsc_pkg::CS_TAIL_CYC - 1);
                            state <= H_TAIL;
                        end
                    end
                end
                H_TAIL: begin
                    if (cnt != 32'h0) begin
                        cnt <= cnt - 32'h1;
                    end else begin
                        link.cs_n <= 1'b1;
                        link.si   <= 1'b0;
                        cnt       <= 32'(swsc_pkg::CS_IDLE_CYC - 1);
                        state     <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (cnt != 32'h0) begin
                        cnt <= cnt - 32'h1;
                    end else if (cur == swsc_pkg::REQ_RECHECK && !pass2) begin
                        pass2 <= 1'b1;
                        cnt   <= 32'(SETTLE_CYC - 1);
                        state <= H_SETTLE;
                    end else begin
                        pass2    <= 1'b0;
                        op_ready <= 1'b1;
                        state    <= H_IDLE;
                        if (cur == swsc_pkg::REQ_STATUS || cur == swsc_pkg::REQ_RECHECK) begin
                            rx_valid  <= 1'b1;
                            rx_word   <= rx;
                            status_ok <= 1'b1;
                        end else if (cur == swsc_pkg::REQ_SLEEP) begin
                            status_ok <= 1'b0;
                        end
                    end
                end
                H_SETTLE: begin
                    if (cnt != 32'h0) begin
                        cnt <= cnt - 32'h1;
                    end else begin
                        tx        <= frame_of(swsc_pkg::OP_STATUS, '0);
                        link.cs_n <= 1'b0;
                        cnt       <= 32'(swsc_pkg::CS_LEAD_CYC - 1);
                        state     <= H_LEAD;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end

endmodule : swsc_host

// ==== design/swsc_link_if.sv ====
// serial chain segment and shared wake line between host and one device
// assumes the bench drives wake_ext_oe for every other puller of the line
`timescale 1ns/1ps
interface swsc_link_if;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic wake_out;
    logic wake_oe;
    logic wake_ext_oe;
    logic wake_in;

    // open-drain line with pull-up: low when any enabled driver pulls low
    assign wake_in = ~((wake_oe & ~wake_out) | wake_ext_oe);

    modport device (
        input  sclk,
        input  cs_n,
        input  si,
        input  wake_in,
        output so,
        output wake_out,
        output wake_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output si,
        input  so,
        input  wake_in
    );
endinterface : swsc_link_if

// ==== design/swsc_pkg.sv ====
// shared constants for the chained switch monitor sleep and wake link
// assumes both ends run clk at 10 MHz; link clock comes from the host
package swsc_pkg;

    // ==============================================================
    // frame geometry
    localparam int N_DEV      = 2;
    localparam int DEV_BITS   = 24;
    localparam int FRAME_BITS = N_DEV * DEV_BITS;
    localparam int BIT_W      = 6;
    localparam int SW_N       = 22;

    // ==============================================================
    // command word fields
    localparam int OP_MSB        = 23;
    localparam int OP_LSB        = 22;
    localparam int WAKE_FLAG_BIT = 22;

    localparam logic [1:0] OP_STATUS = 2'h0;
    localparam logic [1:0] OP_SLEEP  = 2'h1;
    localparam logic [1:0] OP_CONFIG = 2'h2;

    // ==============================================================
    // reset values
    localparam logic [SW_N-1:0] WAKE_EN_RST = 22'h3FFFFF;

    // ==============================================================
    // timing
    localparam int CLK_NS        = 100;
    localparam int CS_LEAD_NS    = 1000;
    localparam int CS_TAIL_NS    = 500;
    localparam int CS_IDLE_NS    = 1000;
    localparam int CS_LEAD_CYC   = (CS_LEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_TAIL_CYC   = (CS_TAIL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CS_IDLE_CYC   = (CS_IDLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int SCLK_HALF_CYC = 4;
    localparam int SETTLE_MS     = 10;
    localparam int SETTLE_MAX_MS = 20;
    localparam int SETTLE_CYC    = (SETTLE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int REFRESH_CYC   = 1000000;

    // ==============================================================
    // types
    typedef enum logic {
        MODE_NORMAL,
        MODE_SLEEP
    } swsc_mode_t;

    typedef enum logic [1:0] {
        REQ_STATUS,
        REQ_SLEEP,
        REQ_CONFIG,
        REQ_RECHECK
    } swsc_op_t;

endpackage : swsc_pkg

// ==== verification/swsc_asserts.sv ====
// checker on the host to first device link segment
// assumes link signals sampled on clk, reset active low
`timescale 1ns/1ps
module swsc_asserts (
    // system
    input wire logic clk,
    input wire logic resetn,
    // link segment
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic so,
    input wire logic wake_out,
    input wire logic wake_oe,
    input wire logic wake_in
);
    // ==========================================
    // helpers: sclk rises per frame, cycles since select rose
    logic [6:0] n_rise;
    logic [3:0] n_since;
    logic       sclk_d;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclk_d  <= 1'b0;
            n_rise  <= 7'h00;
            n_since <= 4'h0;
        end else begin
            sclk_d  <= sclk;
            n_rise  <= cs_n ? 7'h00 : n_rise + {6'h00, sclk & ~sclk_d};
            n_since <= !cs_n ? 4'h0 : n_since + {3'h0, n_since != 4'hF};
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_start; $fell(cs_n); endsequence
    sequence s_quiet; !sclk [*8]; endsequence
    property p_sclk_idle; cs_n |-> !sclk; endproperty
    property p_lead; s_start |-> s_quiet; endproperty
    property p_count; $rose(cs_n) |-> n_rise == 7'h30; endproperty
    property p_so_idle; cs_n && $past(cs_n) |-> !so; endproperty
    property p_od; wake_oe |-> !wake_out; endproperty
    property p_sleep_at_rise; $fell(wake_oe) |-> cs_n && n_since <= 4'h8; endproperty
    property p_frame_wakes; s_start |-> ##[1:5] wake_oe; endproperty
    property p_line_wakes; $fell(wake_in) && !wake_oe |-> ##[1:6] wake_oe; endproperty
    a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves outside frame");
    a_lead: assert property (p_lead) else $error("sclk too soon after select");
    a_count: assert property (p_count) else $error("frame clock count wrong");
    a_so_idle: assert property (p_so_idle) else $error("so driven while deselected");
    a_od: assert property (p_od) else $error("wake line driven high");
    a_sleep_at_rise: assert property (p_sleep_at_rise) else $error("sleep not at select rise");
    a_frame_wakes: assert property (p_frame_wakes) else $error("frame did not wake");
    a_line_wakes: assert property (p_line_wakes) else $error("wake line low did not wake");
endmodule : swsc_asserts

// ==== verification/tb_switch_monitor_sleep_wake_chain.sv ====
// bench: host and two chained devices sharing one select and wake line
// assumes package and link interface compiled first
`timescale 1ns/1ps
module tb_switch_monitor_sleep_wake_chain;
    // ==========================================
    // signals
    logic                            clk, resetn, op_valid, op_ready, rx_valid, refused, got_ref;
    swsc_pkg::swsc_op_t              op_code;
    logic [21:0]                     cfg_data, sw0, sw1;
    logic [47:0]                     rx_word, got;
    logic [1:0]                      sl, wf;
    int                              num_errors, n_compared, cyc;
    swsc_link_if lh();
    swsc_link_if l0();
    swsc_link_if l1();
    assign l0.sclk = lh.sclk;
    assign l0.cs_n = lh.cs_n;
    assign l0.si = lh.si;
    assign l1.sclk = lh.sclk;
    assign l1.cs_n = lh.cs_n;
    assign l1.si = l0.so;
    assign lh.so = l1.so;
    assign l0.wake_ext_oe = l1.wake_oe;
    assign l1.wake_ext_oe = l0.wake_oe;
    assign lh.wake_oe = 1'b0;
    assign lh.wake_out = 1'b0;
    assign lh.wake_ext_oe = l0.wake_oe | l1.wake_oe;
    // ==========================================
    // design and checker
    swsc_host #(.SETTLE_CYC(50), .REFRESH_CYC(2000)) swsc_host_inst (.clk(clk), .resetn(resetn), .link(lh),
        .op_valid(op_valid), .op_code(op_code), .cfg_data(cfg_data), .op_ready(op_ready),
        .rx_valid(rx_valid), .rx_word(rx_word), .refused(refused));
    swsc_device swsc_device_inst_0 (.clk(clk), .resetn(resetn), .link(l0), .sw(sw0), .asleep(sl[0]),
        .wake_flag(wf[0]));
    swsc_device swsc_device_inst_1 (.clk(clk), .resetn(resetn), .link(l1), .sw(sw1), .asleep(sl[1]),
        .wake_flag(wf[1]));
    swsc_asserts swsc_asserts_inst (.clk(clk), .resetn(resetn), .sclk(l0.sclk), .cs_n(l0.cs_n), .so(l0.so),
        .wake_out(l0.wake_out), .wake_oe(l0.wake_oe), .wake_in(l0.wake_in));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard, far above the few thousand cycles expected
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            conclude();
        end
    end
    // ==========================================
    // tasks
    task automatic chk_w(input logic [47:0] g, input logic [47:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: word %h expected %h", $time, g, e);
        end
    endtask : chk_w
    task automatic chk_b(input logic [1:0] g, input logic [1:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("Error at %0t: flags %b expected %b", $time, g, e);
        end
    endtask : chk_b
    task automatic do_op(input swsc_pkg::swsc_op_t op, input logic [21:0] d);
        got_ref = 1'b0;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= op;
        cfg_data <= d;
        @(posedge clk);
        op_valid <= 1'b0;
        // refused stands only for the cycle after the take
        #1;
        if (refused === 1'b1) got_ref = 1'b1;
        for (int i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (rx_valid === 1'b1) got = rx_word;
            if (refused === 1'b1) got_ref = 1'b1;
            if (op_ready === 1'b1 && i > 2) break;
        end
    endtask : do_op
    task automatic settle();
        repeat (12) @(posedge clk);
        #1;
    endtask : settle
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // ==========================================
    // main sequence
    initial begin
        resetn = 1'b0;
        op_valid = 1'b0;
        op_code = swsc_pkg::REQ_STATUS;
        cfg_data = 22'h000000;
        sw0 = 22'h2A5A5A;
        sw1 = 22'h15A5A5;
        num_errors = 0;
        n_compared = 0;
        cyc = 0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        settle();
        chk_b({lh.wake_in, sl[0]}, 2'b00);
        chk_b(sl, 2'b00);
        do_op(swsc_pkg::REQ_STATUS, 22'h000000);
        chk_w(got, {2'b00, sw1, 2'b00, sw0});
        $display("test reset and status done");
        do_op(swsc_pkg::REQ_SLEEP, 22'h000000);
        chk_b({lh.wake_in, sl[1]}, 2'b11);
        chk_b(sl, 2'b11);
        do_op(swsc_pkg::REQ_SLEEP, 22'h000000);
        chk_b({got_ref, sl[0]}, 2'b11);
        $display("test chained sleep done");
        @(posedge clk);
        sw1 <= sw1 ^ 22'h000001;
        settle();
        chk_b(sl, 2'b00);
        chk_b({wf[1], lh.wake_in}, 2'b10);
        do_op(swsc_pkg::REQ_STATUS, 22'h000000);
        chk_w(got, {2'b01, sw1, 2'b00, sw0});
        chk_b(wf, 2'b00);
        $display("test switch wake done");
        do_op(swsc_pkg::REQ_SLEEP, 22'h000000);
        do_op(swsc_pkg::REQ_STATUS, 22'h000000);
        chk_b(sl, 2'b00);
        $display("test frame wake done");
        fork
            do_op(swsc_pkg::REQ_SLEEP, 22'h000000);
            begin
                wait (lh.cs_n === 1'b0);
                repeat (50) @(posedge clk);
                sw0 <= sw0 ^ 22'h000100;
            end
        join
        chk_b(sl, 2'b10);
        do_op(swsc_pkg::REQ_RECHECK, 22'h000000);
        chk_b(sl, 2'b00);
        chk_w(got, {2'b00, sw1, 2'b00, sw0});
        do_op(swsc_pkg::REQ_CONFIG, 22'h3FFFFF);
        chk_b(sl, 2'b00);
        $display("test split sleep and recheck done");
        // host must start a config rewrite on its own once configured
        fork : refresh_wait
            wait (op_ready === 1'b0);
            repeat (2100) @(posedge clk);
        join_any
        disable refresh_wait;
        #1;
        chk_b({op_ready, lh.cs_n}, 2'b00);
        $display("test refresh done");
        conclude();
    end
endmodule : tb_switch_monitor_sleep_wake_chain
